// [design/gtl_pkg.sv]
// Constants and types shared by the 64 kbps co-directional timing and loopback block.
// Assumes a single 40 MHz system clock and a synchronous, active-high reset.
//
// Notes on behaviour
// - Line channel runs only at 64 kbps; no other line rate exists.
// - No data-rate configuration input; the fixed rate ignores any such setting.
// - Octet switch off disables the marker except in minimum loopback; on produces an 8 kHz octet marker.
// - With octet timing on, mark the violation carried on bit 8 of each octet.
// - Mode switches: 00 loop, A only internal, B only minimum loopback, both dual.
// - Internal timing: transmit strobe comes from the internal divider only.
// - Loop timing: transmit strobe follows the received line strobe.
// - After reset: loop timing and octet timing enabled until switches are sampled.
// - Minimum loopback: received bit, polarity restored, latched and sent back unchanged.
// - Minimum loopback: internal-side words are still drained, then dropped.
// - Minimum loopback: line receiver keeps feeding the internal transmitter.
// - Minimum loopback: timing returned as received; line side supplies the clock.
// - Dual loopback: internal receiver words go straight back to internal transmitter.
// - Dual loopback: line receiver bits go straight back onto the line.
// - Dual loopback: each side times its own return path from its own source.

package gtl_pkg;

    // ==========================================================
    // Clock and line rate
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned LINE_RATE_BPS  = 64_000;
    localparam int unsigned BIT_CYCLES     = CLK_HZ / LINE_RATE_BPS;   // 625 cycles a bit
    localparam int unsigned OCTET_RATE_HZ  = 8_000;
    localparam int unsigned OCTET_BITS     = LINE_RATE_BPS / OCTET_RATE_HZ;

    // ==========================================================
    // Octet framing
    localparam logic [2:0]  OCTET_MARK_POS = 3'h7;   // Bit 8, the LSB, of each octet
    localparam logic        IDLE_BIT       = 1'b1;   // Sent on the line when nothing waits

    // ==========================================================
    // Buffering
    localparam int unsigned BUF_DEPTH      = 2;
    localparam int unsigned BUF_WIDTH      = 1;

    // ==========================================================
    // Modes, Gray coded along loop, internal, dual, minimum
    typedef enum logic [1:0] {
        GTL_LOOP     = 2'h0,
        GTL_INTERNAL = 2'h1,
        GTL_DUAL_LB  = 2'h3,
        GTL_MIN_LB   = 2'h2
    } gtl_mode_t;

    // ==========================================================
    // Reset values
    localparam gtl_mode_t   RST_MODE       = GTL_LOOP;
    localparam logic        RST_OCTET_EN   = 1'b1;

endpackage : gtl_pkg

// [design/gtl_bit_timer.sv]
// Internal bit-rate divider: one-cycle tick every CYCLES system clocks.
// Assumes one system clock and a synchronous, active-high reset.
`timescale 1ns/100ps
`default_nettype none

module gtl_bit_timer #(
    parameter int unsigned CYCLES = gtl_pkg::BIT_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Rate enable
    output logic      tick
);

    localparam int unsigned CW = $clog2(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } gtl_tmr_t;

    gtl_tmr_t s_ff;
    gtl_tmr_t nxt_s;

    // ==========================================================
    // Divider
    // Fixed terminal count: no rate setting can reach it
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.tick = 1'b0;
        if (s_ff.cnt == CW'(CYCLES - 1)) begin
            nxt_s.cnt  = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;

endmodule : gtl_bit_timer
`default_nettype wire

// [design/gtl_pair_buf.sv]
// Small FIFO with valid/ready on both sides; two entries by default.
// Assumes one system clock and a synchronous, active-high reset.
`timescale 1ns/100ps
`default_nettype none

module gtl_pair_buf #(
    parameter int unsigned WIDTH = gtl_pkg::BUF_WIDTH,
    parameter int unsigned DEPTH = gtl_pkg::BUF_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned NW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [NW-1:0]               count;
        logic                        in_ready;
    } gtl_buf_t;

    gtl_buf_t s_ff;
    gtl_buf_t nxt_s;
    logic     do_wr;
    logic     do_rd;

    // ==========================================================
    // Pointers and count
    // Ready is registered, so a full buffer refuses one cycle longer at worst
    always_comb begin
        nxt_s = s_ff;
        do_wr = in_valid && s_ff.in_ready;
        do_rd = out_ready && (s_ff.count != '0);
        if (do_wr) begin
            nxt_s.mem[s_ff.wr_ptr] = in_data;
            nxt_s.wr_ptr = (s_ff.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_ff.wr_ptr + PW'(1);
        end
        if (do_rd) begin
            nxt_s.rd_ptr = (s_ff.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_ff.rd_ptr + PW'(1);
        end
        if (do_wr && !do_rd) begin
            nxt_s.count = s_ff.count + NW'(1);
        end else if (do_rd && !do_wr) begin
            nxt_s.count = s_ff.count - NW'(1);
        end
        nxt_s.in_ready = (nxt_s.count != NW'(DEPTH));
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff          <= '0;
            s_ff.in_ready <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign in_ready  = s_ff.in_ready;
    assign out_valid = (s_ff.count != '0);
    assign out_data  = s_ff.mem[s_ff.rd_ptr];

endmodule : gtl_pair_buf
`default_nettype wire

// [design/gtl_codir_top.sv]
// Timing and loopback control between a 64 kbps co-directional line and the
// internal Differential Manchester link. Bits on both sides are already decoded.
// Assumes line receive bits arrive with a one-cycle strobe from the line clock
// recovery, and that the internal side uses valid/ready handshakes.
`timescale 1ns/100ps
`default_nettype none

module gtl_codir_top (
    // Clock and reset
    input  wire logic CLK_SYS,
    input  wire logic SYS_RST,
    // Timing selection switches
    input  wire logic OCTET_TIMING_SWITCH,
    input  wire logic TIMING_MODE_SWITCH_A,
    input  wire logic TIMING_MODE_SWITCH_B,
    // Line receiver (decoded)
    input  wire logic LINE_RX_STB,
    input  wire logic LINE_RX_BIT,
    input  wire logic LINE_RX_POL_INV,
    input  wire logic LINE_RX_VIOL,
    // Line transmitter (to encoder)
    output logic      LINE_TX_STB,
    output logic      LINE_TX_BIT,
    output logic      LINE_TX_OCTET,
    // Differential Manchester receiver side
    input  wire logic DM_RX_VALID,
    input  wire logic DM_RX_BIT,
    output logic      DM_RX_READY,
    // Differential Manchester transmitter side
    output logic      DM_TX_VALID,
    output logic      DM_TX_BIT,
    input  wire logic DM_TX_READY,
    // Status
    output logic [1:0] MODE_ACTIVE,
    output logic      DM_TX_OVERRUN
);

    typedef struct packed {
        gtl_pkg::gtl_mode_t mode;
        logic               octet_en;
        logic [2:0]         bit_cnt;
        logic               tx_stb;
        logic               tx_bit;
        logic               tx_octet;
        logic               dmtx_valid;
        logic               dmtx_bit;
        logic               overrun;
    } gtl_top_t;

    gtl_top_t s_ff;
    gtl_top_t nxt_s;

    logic tick_int;
    logic tx_stb_src;
    logic rx_bit_fixed;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_data;
    logic buf_out_ready;

    // ==========================================================
    // Internal bit timer, fixed at the line rate; there is no rate input at all
    gtl_bit_timer #(
        .CYCLES (gtl_pkg::BIT_CYCLES)
    ) u_timer (
        .clk  (CLK_SYS),
        .rst  (SYS_RST),
        .tick (tick_int)
    );

    // ==========================================================
    // Buffer between internal receiver and line transmitter
    // Drains once per line bit outside dual loopback, so the internal receiver is stalled through DM_RX_READY
    gtl_pair_buf #(
        .WIDTH (gtl_pkg::BUF_WIDTH),
        .DEPTH (gtl_pkg::BUF_DEPTH)
    ) u_buf (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .in_valid  (DM_RX_VALID),
        .in_data   (DM_RX_BIT),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_out_ready)
    );

    // ==========================================================
    // Timing source and polarity restore
    // Only internal mode times from the divider; every other mode returns line timing
    assign tx_stb_src   = (s_ff.mode == gtl_pkg::GTL_INTERNAL) ? tick_int
                                                               : LINE_RX_STB;
    assign rx_bit_fixed = LINE_RX_BIT ^ LINE_RX_POL_INV;

    // Drain control for the buffer
    always_comb begin
        unique case (s_ff.mode)
            gtl_pkg::GTL_DUAL_LB:  buf_out_ready = !s_ff.dmtx_valid || DM_TX_READY;
            gtl_pkg::GTL_MIN_LB:   buf_out_ready = tx_stb_src;
            gtl_pkg::GTL_LOOP,
            gtl_pkg::GTL_INTERNAL: buf_out_ready = tx_stb_src;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.tx_stb   = 1'b0;
        nxt_s.overrun  = 1'b0;
        // Switches are static straps but are resampled so a change takes effect
        nxt_s.mode     = gtl_pkg::gtl_mode_t'({TIMING_MODE_SWITCH_B,
                                               TIMING_MODE_SWITCH_A});
        nxt_s.octet_en = OCTET_TIMING_SWITCH;

        // Line transmit path
        if (tx_stb_src) begin
            nxt_s.tx_stb  = 1'b1;
            nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
            nxt_s.tx_octet = s_ff.octet_en
                          && (s_ff.bit_cnt == gtl_pkg::OCTET_MARK_POS);
            unique case (s_ff.mode)
                gtl_pkg::GTL_MIN_LB: begin
                    // Unprocessed return: violations go back as received
                    nxt_s.tx_bit   = rx_bit_fixed;
                    nxt_s.tx_octet = LINE_RX_VIOL;
                end
                gtl_pkg::GTL_DUAL_LB: begin
                    nxt_s.tx_bit = rx_bit_fixed;
                end
                gtl_pkg::GTL_LOOP,
                gtl_pkg::GTL_INTERNAL: begin
                    nxt_s.tx_bit = buf_out_valid ? buf_out_data
                                                 : gtl_pkg::IDLE_BIT;
                end
            endcase
        end

        // Internal transmit path; accepted word frees the slot first
        if (s_ff.dmtx_valid && DM_TX_READY) begin
            nxt_s.dmtx_valid = 1'b0;
        end
        if (s_ff.mode == gtl_pkg::GTL_DUAL_LB) begin
            if (buf_out_valid && buf_out_ready) begin
                nxt_s.dmtx_valid = 1'b1;
                nxt_s.dmtx_bit   = buf_out_data;
            end
        end else if (LINE_RX_STB) begin
            // A bit still unaccepted is overwritten; the loss is flagged
            nxt_s.overrun    = s_ff.dmtx_valid && !DM_TX_READY;
            nxt_s.dmtx_valid = 1'b1;
            nxt_s.dmtx_bit   = rx_bit_fixed;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s_ff          <= '0;
            s_ff.mode     <= gtl_pkg::RST_MODE;
            s_ff.octet_en <= gtl_pkg::RST_OCTET_EN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs, all from flops
    assign LINE_TX_STB   = s_ff.tx_stb;
    assign LINE_TX_BIT   = s_ff.tx_bit;
    assign LINE_TX_OCTET = s_ff.tx_octet;
    assign DM_TX_VALID   = s_ff.dmtx_valid;
    assign DM_TX_BIT     = s_ff.dmtx_bit;
    assign DM_RX_READY   = buf_in_ready;
    assign MODE_ACTIVE   = s_ff.mode;
    assign DM_TX_OVERRUN = s_ff.overrun;

    // ==========================================================
    // Checks
    // Helper: cycles since the last internal tick
    logic [9:0] gap_cnt_ff;
    logic       gap_seen_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            gap_cnt_ff  <= 10'h000;
            gap_seen_ff <= 1'b0;
        end else if (tick_int) begin
            gap_cnt_ff  <= 10'h000;
            gap_seen_ff <= 1'b1;
        end else begin
            gap_cnt_ff  <= gap_cnt_ff + 10'h001;
        end
    end

    rate_fixed_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        tick_int && gap_seen_ff |-> gap_cnt_ff == 10'(gtl_pkg::BIT_CYCLES - 1))
        else $error("internal bit tick spacing wrong");

    mode_decode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ##1 MODE_ACTIVE == {$past(TIMING_MODE_SWITCH_B), $past(TIMING_MODE_SWITCH_A)})
        else $error("mode does not follow switches");

    reset_default_a: assert property (@(posedge CLK_SYS)
        SYS_RST |=> s_ff.mode == gtl_pkg::GTL_LOOP && s_ff.octet_en)
        else $error("reset defaults wrong");

    octet_mark_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        tx_stb_src && s_ff.mode != gtl_pkg::GTL_MIN_LB
        |=> LINE_TX_OCTET == ($past(s_ff.octet_en)
                              && $past(s_ff.bit_cnt) == gtl_pkg::OCTET_MARK_POS))
        else $error("octet marker misplaced");

    // The marker holds between strobes, so only a fresh strobe must be clear
    octet_off_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !s_ff.octet_en && s_ff.mode != gtl_pkg::GTL_MIN_LB
        |=> !(LINE_TX_STB && LINE_TX_OCTET))
        else $error("octet marker while disabled");

    internal_timing_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_INTERNAL |=> LINE_TX_STB == $past(tick_int))
        else $error("internal timing not from divider");

    loop_timing_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode != gtl_pkg::GTL_INTERNAL |=> LINE_TX_STB == $past(LINE_RX_STB))
        else $error("line timing not returned");

    min_loop_data_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_MIN_LB && LINE_RX_STB
        |=> LINE_TX_BIT == $past(rx_bit_fixed) && LINE_TX_OCTET == $past(LINE_RX_VIOL))
        else $error("minimum loopback data altered");

    min_loop_drop_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_MIN_LB && buf_out_valid && tx_stb_src
        |-> buf_out_ready
        ##1 (LINE_TX_BIT == $past(rx_bit_fixed) && DM_TX_BIT == $past(rx_bit_fixed)))
        else $error("internal data leaked in minimum loopback");

    rx_forward_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode != gtl_pkg::GTL_DUAL_LB && LINE_RX_STB
        |=> DM_TX_VALID && DM_TX_BIT == $past(rx_bit_fixed))
        else $error("line bit not forwarded inward");

    dual_dm_loop_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_DUAL_LB && buf_out_valid && buf_out_ready
        |=> DM_TX_VALID && DM_TX_BIT == $past(buf_out_data))
        else $error("dual loopback inner path broken");

    dual_line_loop_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_DUAL_LB && LINE_RX_STB
        |=> LINE_TX_STB && LINE_TX_BIT == $past(rx_bit_fixed))
        else $error("dual loopback line path broken");

    normal_out_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_LOOP && LINE_RX_STB && buf_out_valid
        |=> LINE_TX_BIT == $past(buf_out_data))
        else $error("inner data not sent on line");

    // ==========================================================
    // Handshake, idle and reset checks
    // A pending inward bit may only be replaced by a fresh line bit, and that loss is flagged
    overrun_flag_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode != gtl_pkg::GTL_DUAL_LB && LINE_RX_STB && DM_TX_VALID && !DM_TX_READY
        |=> DM_TX_OVERRUN)
        else $error("lost inward bit not flagged");

    dm_tx_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        DM_TX_VALID && !DM_TX_READY && (s_ff.mode == gtl_pkg::GTL_DUAL_LB || !LINE_RX_STB)
        |=> DM_TX_VALID && $stable(DM_TX_BIT))
        else $error("inward word dropped while stalled");

    dual_no_overrun_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_DUAL_LB |=> !DM_TX_OVERRUN)
        else $error("line bit reached inner side in dual loopback");

    idle_bit_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode != gtl_pkg::GTL_DUAL_LB && s_ff.mode != gtl_pkg::GTL_MIN_LB
        && tx_stb_src && !buf_out_valid
        |=> LINE_TX_BIT == gtl_pkg::IDLE_BIT)
        else $error("idle bit not sent on empty buffer");

    // Refusal only ever means the buffer is holding words
    rx_refuse_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !DM_RX_READY |-> buf_out_valid)
        else $error("inward buffer refuses while empty");

    reset_quiet_a: assert property (@(posedge CLK_SYS)
        SYS_RST |=> !LINE_TX_STB && !DM_TX_VALID && !DM_TX_OVERRUN)
        else $error("outputs not quiet after reset");

    // ==========================================================
    // Covers for dual and minimum loopback, octet marker, full buffer and overrun

    cov_dual_c:    cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_DUAL_LB && buf_out_valid && buf_out_ready);
    cov_min_lb_c:  cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_ff.mode == gtl_pkg::GTL_MIN_LB && LINE_RX_STB && buf_out_valid);
    cov_octet_c:   cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        LINE_TX_STB && LINE_TX_OCTET);
    cov_full_c:    cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        DM_RX_VALID && !DM_RX_READY);
    cov_overrun_c: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        DM_TX_OVERRUN);

endmodule : gtl_codir_top
`default_nettype wire

// [test/gtl_line_peer.sv]
// Line-side peer model: decoded receive bits with strobes from its own period counter.
// Assumes the bench clock; all outputs change at the falling edge.
`timescale 1ns/100ps
`default_nettype none

module gtl_line_peer (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [9:0] period,
    // Decoded line receive
    output logic            stb,
    output logic            rx_bit,
    output logic            pol_inv,
    output logic            viol
);
    // ==========================================================
    // Own timing source
    logic [9:0]  cnt  = 10'h000;
    logic [31:0] seed = 32'h6837b296;

    // Known levels at time zero
    initial {stb, rx_bit, pol_inv, viol} = 4'h0;

    // Strobe every period+1 cycles; data flips between strobes, never holds
    always @(negedge clk) begin
        stb <= 1'b0;
        {viol, pol_inv, rx_bit} <= ~{viol, pol_inv, rx_bit};
        cnt <= cnt + 10'h001;
        if (run && cnt >= period) begin
            cnt <= 10'h000;
            stb <= 1'b1;
            {viol, pol_inv, rx_bit} <= 3'($random(seed));
        end
    end
endmodule : gtl_line_peer

`default_nettype wire

// [test/tb_gtl_codir_top.sv]
// Self-checking bench for the timing and loopback block.
// Assumes the line peer model and the design top; one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_gtl_codir_top;
    // ==========================================================
    // Signals
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic       oct_sw  = 1'b1;
    logic       sw_a    = 1'b0;
    logic       sw_b    = 1'b0;
    logic       run     = 1'b0;
    logic       rx_stb, rx_bit, rx_pol, rx_viol;
    logic       tx_stb, tx_bit, tx_oct, dm_ovr;
    logic       dm_rx_valid = 1'b0;
    logic       dm_rx_bit   = 1'b0;
    logic       dm_rx_ready, dm_tx_valid, dm_tx_bit;
    logic       dm_tx_ready = 1'b1;
    logic       stall   = 1'b0;
    logic       prev_rx = 1'b0;
    logic [1:0] mode_act;
    logic [1:0] mode    = 2'h0;
    logic [31:0] seed   = 32'h6837b296;
    int         n_mismatch = 0, checks = 0, n_tx = 0, n_ovr = 0, cyc = 0, last_tx = 0;
    logic       bufq[$], dmq[$], rxq[$], violq[$];

    gtl_line_peer peer (.clk(clk_sys), .run(run), .period(10'h025), .stb(rx_stb),
        .rx_bit(rx_bit), .pol_inv(rx_pol), .viol(rx_viol));

    gtl_codir_top DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .OCTET_TIMING_SWITCH(oct_sw),
        .TIMING_MODE_SWITCH_A(sw_a), .TIMING_MODE_SWITCH_B(sw_b), .LINE_RX_STB(rx_stb),
        .LINE_RX_BIT(rx_bit), .LINE_RX_POL_INV(rx_pol), .LINE_RX_VIOL(rx_viol),
        .LINE_TX_STB(tx_stb), .LINE_TX_BIT(tx_bit), .LINE_TX_OCTET(tx_oct),
        .DM_RX_VALID(dm_rx_valid), .DM_RX_BIT(dm_rx_bit), .DM_RX_READY(dm_rx_ready),
        .DM_TX_VALID(dm_tx_valid), .DM_TX_BIT(dm_tx_bit), .DM_TX_READY(dm_tx_ready),
        .MODE_ACTIVE(mode_act), .DM_TX_OVERRUN(dm_ovr));

    // 25 ns clock
    always #12.5 clk_sys = ~clk_sys;

    // ==========================================================
    // Tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic results();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // Line transmit strobe: timing source, bit and octet marker
    task automatic check_tx();
        logic e_bit, e_oct;
        e_oct = oct_sw && (n_tx % 8 == 7);
        if (mode[1]) e_bit = rxq.pop_front();
        else e_bit = (bufq.size() > 0) ? bufq.pop_front() : 1'b1;
        if (mode == 2'h2) begin
            e_oct = violq.pop_front();
            if (bufq.size() > 0) void'(bufq.pop_front());
        end
        if (mode != 2'h1) cmp(prev_rx, 1'b1);
        else if (last_tx > 0) cmp(16'(cyc - last_tx), 16'h0271);
        cmp(tx_bit, e_bit);
        cmp(tx_oct, e_oct);
        last_tx = cyc;
        n_tx++;
    endtask : check_tx

    // Hold the word until it is taken; valid stays up for the caller
    task automatic send_dm(input logic b);
        int t;
        t = 0;
        dm_rx_valid <= 1'b1;
        dm_rx_bit <= b;
        @(posedge clk_sys);
        while (dm_rx_ready !== 1'b1 && t < 2000) begin
            t++;
            @(posedge clk_sys);
        end
        if (t >= 2000) n_mismatch++;
        @(negedge clk_sys);
    endtask : send_dm

    task automatic wait_tx();
        int t;
        t = 0;
        @(posedge clk_sys);
        while (tx_stb !== 1'b1 && t < 2000) begin
            t++;
            @(posedge clk_sys);
        end
        if (t >= 2000) n_mismatch++;
        @(negedge clk_sys);
    endtask : wait_tx

    // Switch settings {octet, B, A}, then n line strobes with words offered after each
    task automatic phase(input logic [2:0] cfg, input int n);
        run <= 1'b0;
        if (mode == 2'h1) wait_tx(); // Leave internal just after a tick
        else repeat (40) @(negedge clk_sys);
        {oct_sw, sw_b, sw_a} <= cfg;
        repeat (2) @(negedge clk_sys);
        mode = cfg[1:0];
        // Words parked in the buffer leave inward once dual loopback starts
        if (mode == 2'h3) while (bufq.size() > 0) dmq.push_back(bufq.pop_front());
        last_tx = 0;
        cmp(mode_act, cfg[1:0]);
        run <= 1'b1;
        repeat (n) begin
            wait_tx();
            repeat (($random(seed) & 1) + 1) send_dm(1'($random(seed)));
            dm_rx_valid <= 1'b0;
        end
    endtask : phase

    // ==========================================================
    // Watcher: notes expectations from inputs, compares outputs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (!sys_rst) begin
            if (dm_ovr) begin
                n_ovr++;
                void'(dmq.pop_front());
            end
            if (dm_tx_valid && dm_tx_ready) cmp(dm_tx_bit, dmq.pop_front());
            if (tx_stb) check_tx();
            if (rx_stb && mode != 2'h3) dmq.push_back(rx_bit ^ rx_pol);
            if (rx_stb && mode[1]) rxq.push_back(rx_bit ^ rx_pol);
            if (rx_stb && mode == 2'h2) violq.push_back(rx_viol);
            if (dm_rx_valid && dm_rx_ready) begin
                if (mode == 2'h3) dmq.push_back(dm_rx_bit);
                else bufq.push_back(dm_rx_bit);
            end
            prev_rx <= rx_stb;
        end
    end

    // Receiver stalls at random, or solidly when asked
    always @(negedge clk_sys) dm_tx_ready <= !stall && (($random(seed) & 3) != 0);

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(negedge clk_sys);
        cmp(mode_act, 2'h0);
        cmp(dm_rx_ready, 1'b1);
        sys_rst <= 1'b0;
        phase(3'b100, 12);
        phase(3'b101, 3);
        phase(3'b110, 12);
        phase(3'b111, 12);
        phase(3'b001, 9);
        phase(3'b100, 4);
        repeat (100) @(negedge clk_sys);
        // Fill the inward buffer while the line is silent
        run <= 1'b0;
        repeat (40) @(negedge clk_sys);
        send_dm(1'b0);
        send_dm(1'b1);
        cmp(dm_rx_ready, 1'b0);
        run <= 1'b1;
        send_dm(1'b0);
        dm_rx_valid <= 1'b0;
        cmp(n_ovr, 0);
        // Solid stall loses older inward bits and flags them
        stall <= 1'b1;
        repeat (100) @(negedge clk_sys);
        stall <= 1'b0;
        repeat (200) @(negedge clk_sys);
        run <= 1'b0;
        repeat (100) @(negedge clk_sys);
        cmp(n_ovr > 0, 1'b1);
        cmp(dmq.size() + rxq.size() + bufq.size(), 0);
        results();
    end
endmodule : tb_gtl_codir_top

`default_nettype wire
